/* logic/ssa_map.svh */
`ifndef SSA_MAP_SVH
`define SSA_MAP_SVH
// ***********************************
// register byte offsets
// ***********************************
`define SSA_CTRL_OFS 8'h00
`define SSA_BAUD_OFS 8'h04
`define SSA_RHB_OFS 8'h08
`define SSA_THB_OFS 8'h0c
`define SSA_STAT_OFS 8'h10
// channel n at 8'h80 + n*8'h10, field in addr[3:2]
`define SSA_CH_SEL 2'h2
`define SSA_CH_SRC 2'h0
`define SSA_CH_DST 2'h1
`define SSA_CH_CNT 2'h2
`define SSA_CH_CTL 2'h3
// ***********************************
// field positions
// ***********************************
`define SSA_CTRL_CLKSEL 0
`define SSA_CTRL_CONTRX 1
`define SSA_CTRL_TXREQ 2
`define SSA_CTL_EN 0
`define SSA_CTL_BLK 1
`define SSA_CTL_SIZE 2
`define SSA_CTL_SFWD 4
`define SSA_CTL_DFWD 5
`define SSA_CTL_RSEL 6
`define SSA_CTL_TRIG 8
`define SSA_ST_THBF 4
`define SSA_ST_ARMED 5
`define SSA_ST_OVR 6
`define SSA_ST_BUSY 7
// ***********************************
// reset values and engine view of buffers
// ***********************************
`define SSA_BAUD_RST 8'h03
`define SSA_RHB_ADDR 32'hffff_0008
`define SSA_THB_ADDR 32'hffff_000c
`endif

/* logic/ssa_pkg.sv */
package ssa_pkg;
   typedef enum logic [1:0] {SSA_IDLE = 2'b00, SSA_RD = 2'b01, SSA_WR = 2'b11} ssa_dma_st_t;
   typedef enum logic [1:0] {SSA_BYTE = 2'h0, SSA_WORD = 2'h1, SSA_LONG = 2'h2} ssa_size_t;
   typedef enum logic [1:0] {SSA_REQ_NONE = 2'h0, SSA_REQ_RX = 2'h1, SSA_REQ_TX = 2'h2,
      SSA_REQ_SW = 2'h3} ssa_rsel_t;
   typedef struct packed {
      logic [1:0] ck_s;
      logic [1:0] rx_s;
      logic ck_d;
      logic [7:0] div;
      logic sck;
      logic [7:0] rsh;
      logic [2:0] rcnt;
      logic [7:0] rhb;
      logic armed;
      logic ovr;
      logic rxq;
      logic [7:0] tsh;
      logic [2:0] tcnt;
      logic tbusy;
      logic [7:0] thb;
      logic tfull;
      logic txq;
      logic txd;
   } ssa_ser_st_t;
   typedef struct packed {
      logic [31:0] rdata;
      logic clk_sel;
      logic cont_rx;
      logic txq_en;
      logic [7:0] baud;
      logic [3:0][31:0] src;
      logic [3:0][31:0] dst;
      logic [3:0][15:0] cnt;
      logic [3:0][1:0] size;
      logic [3:0][1:0] rsel;
      logic [3:0] en;
      logic [3:0] blk;
      logic [3:0] sfwd;
      logic [3:0] dfwd;
      logic [3:0] pend;
      logic [3:0] done;
      logic [3:0] dpulse;
      ssa_dma_st_t st;
      logic [1:0] ch;
      logic [31:0] data;
      logic [31:0] maddr;
      logic [31:0] mwdata;
      logic [1:0] msize;
      logic mrd;
      logic mwr;
      logic rhb_rd;
      logic thb_wr;
      logic [7:0] thb_d;
   } ssa_top_st_t;
endpackage

/* logic/ssa_serial.sv */
`timescale 1ns/1ps
module ssa_serial (
   input logic sys_clk_i,
   input logic reset_i,
   input logic ext_clk_i,
   input logic rxd_i,
   input logic clk_sel_i,
   input logic cont_rx_i,
   input logic tx_req_en_i,
   input logic [7:0] baud_div_i,
   input logic rhb_rd_i,
   input logic thb_wr_i,
   input logic [7:0] thb_data_i,
   output logic [7:0] rhb_o,
   output logic rx_req_o,
   output logic tx_req_o,
   output logic txd_o,
   output logic sck_o,
   output logic thb_full_o,
   output logic rx_armed_o,
   output logic overrun_o
);
   import ssa_pkg::*;
   ssa_ser_st_t s, n;
   logic lvl, rise, fall, load;

   // switching the source mid-byte can fake an edge; change it only while idle
   assign lvl = clk_sel_i ? s.ck_s[1] : s.sck;
   assign rise = lvl & ~s.ck_d;
   assign fall = ~lvl & s.ck_d;
   assign load = s.tfull & (~s.tbusy | (fall & (s.tcnt == 3'h7)));

   always_comb begin
      n = s;
      n.rxq = 1'b0;
      n.txq = 1'b0;
      n.ck_s = {s.ck_s[0], ext_clk_i};
      n.rx_s = {s.rx_s[0], rxd_i};
      n.ck_d = lvl;
      if (s.div == baud_div_i) begin
         n.div = 8'h00;
         n.sck = ~s.sck;
      end else begin
         n.div = s.div + 8'h01;
      end
      if (rhb_rd_i) begin
         n.ovr = 1'b0;
      end
      if (rise) begin
         n.rsh = {s.rsh[6:0], s.rx_s[1]};
         n.rcnt = s.rcnt + 3'h1;
         if (s.rcnt == 3'h7) begin
            if (s.armed) begin
               n.rhb = {s.rsh[6:0], s.rx_s[1]};
               n.rxq = 1'b1;
               n.armed = 1'b0;
            end else begin
               n.ovr = 1'b1;
            end
         end
      end
      // arming after the copy so a read in the copy cycle is not lost
      if (cont_rx_i ? rhb_rd_i : thb_wr_i) begin
         n.armed = 1'b1;
      end
      if (fall && s.tbusy) begin
         n.tsh = {s.tsh[6:0], 1'b0};
         n.txd = s.tsh[6];
         n.tcnt = s.tcnt + 3'h1;
         if (s.tcnt == 3'h7) begin
            n.tbusy = 1'b0;
            n.txd = 1'b0;
         end
      end
      if (load) begin
         n.tsh = s.thb;
         n.txd = s.thb[7];
         n.tcnt = 3'h0;
         n.tbusy = 1'b1;
         n.tfull = 1'b0;
         n.txq = tx_req_en_i;
      end
      if (thb_wr_i) begin
         n.thb = thb_data_i;
         n.tfull = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign rhb_o = s.rhb;
   assign rx_req_o = s.rxq;
   assign tx_req_o = s.txq;
   assign txd_o = s.txd;
   assign sck_o = s.sck;
   assign thb_full_o = s.tfull;
   assign rx_armed_o = s.armed;
   assign overrun_o = s.ovr;

   // ***********************************
   // checks
   // ***********************************
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);
   a_rx_byte_spacing: assert property (s.rxq |=> (!s.rxq)[*8])
      else $error("receive requests closer than one byte");
   a_rx_copy_req: assert property ((rise && s.rcnt == 3'h7 && s.armed) |=>
      (s.rxq && s.rhb == {$past(s.rsh[6:0]), $past(s.rx_s[1])}))
      else $error("received byte not copied with request");
   a_read_arms: assert property ((cont_rx_i && rhb_rd_i) |=> s.armed)
      else $error("read did not arm reception");
   a_tx_load_msb: assert property ((load && !thb_wr_i) |=>
      (s.tbusy && !s.tfull && s.txd == $past(s.thb[7])))
      else $error("held byte not loaded msb first");
   a_tx_req_load: assert property ((load && tx_req_en_i) |=> s.txq)
      else $error("no transmit request on empty buffer");
   a_tx_shift_order: assert property ((fall && s.tbusy && s.tcnt != 3'h7 && !load) |=>
      (s.txd == $past(s.tsh[6])))
      else $error("transmit bit order wrong");
endmodule

/* logic/ssa_top.sv */
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "ssa_map.svh"
module ssa_top (
   input logic sys_clk_i,
   input logic reset_i,
   input logic [7:0] reg_addr_i,
   input logic [31:0] reg_wdata_i,
   input logic reg_wr_i,
   input logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   input logic external_serial_clock_pin_i,
   input logic serial_rx_i,
   output logic serial_tx_o,
   output logic serial_clk_o,
   output logic [31:0] mem_addr_o,
   output logic [1:0] mem_size_o,
   output logic [31:0] mem_wdata_o,
   output logic mem_rd_o,
   output logic mem_wr_o,
   input logic [31:0] mem_rdata_i,
   input logic mem_ack_i,
   output logic [3:0] xfer_done_o
);
   import ssa_pkg::*;
   ssa_top_st_t s, n;
   logic [7:0] rhb;
   logic rx_req;
   logic tx_req;
   logic thb_full;
   logic rx_armed;
   logic overrun;
   logic [3:0] go;
   logic hit;
   logic [1:0] pk;
   logic [1:0] wc;

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);

   // ***********************************
   // serial unit
   // ***********************************
   ssa_serial u_ser (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .ext_clk_i(external_serial_clock_pin_i),
      .rxd_i(serial_rx_i),
      .clk_sel_i(s.clk_sel),
      .cont_rx_i(s.cont_rx),
      .tx_req_en_i(s.txq_en),
      .baud_div_i(s.baud),
      .rhb_rd_i(s.rhb_rd),
      .thb_wr_i(s.thb_wr),
      .thb_data_i(s.thb_d),
      .rhb_o(rhb),
      .rx_req_o(rx_req),
      .tx_req_o(tx_req),
      .txd_o(serial_tx_o),
      .sck_o(serial_clk_o),
      .thb_full_o(thb_full),
      .rx_armed_o(rx_armed),
      .overrun_o(overrun)
   );

   // ***********************************
   // channel arbitration
   // ***********************************
   // fixed priority, channel 0 first; a block channel stays pending until done, but a lower-numbered channel still wins each pick
   assign go = s.pend & s.en;
   assign hit = |go;
   assign pk = go[0] ? 2'h0 : go[1] ? 2'h1 : go[2] ? 2'h2 : 2'h3;
   assign wc = reg_addr_i[5:4];

   function automatic logic [31:0] ssa_unit(input logic [1:0] sz);
      case (sz)
         SSA_WORD: ssa_unit = 32'h0000_0002;
         SSA_LONG: ssa_unit = 32'h0000_0004;
         default: ssa_unit = 32'h0000_0001;
      endcase
   endfunction

   // ***********************************
   // next state
   // ***********************************
   always_comb begin
      logic go_wr;
      logic fin;
      logic [1:0] c;
      go_wr = 1'b0;
      fin = 1'b0;
      c = (s.st == SSA_IDLE) ? pk : s.ch;
      n = s;
      n.dpulse = 4'h0;
      n.rhb_rd = 1'b0;
      n.thb_wr = 1'b0;
      n.mrd = 1'b0;
      n.mwr = 1'b0;
      n.rdata = 32'h0000_0000;
      if (reg_wr_i) begin
         case (reg_addr_i)
            `SSA_CTRL_OFS: begin
               n.clk_sel = reg_wdata_i[`SSA_CTRL_CLKSEL];
               n.cont_rx = reg_wdata_i[`SSA_CTRL_CONTRX];
               n.txq_en = reg_wdata_i[`SSA_CTRL_TXREQ];
            end
            `SSA_BAUD_OFS: begin
               n.baud = reg_wdata_i[7:0];
            end
            `SSA_THB_OFS: begin
               n.thb_wr = 1'b1;
               n.thb_d = reg_wdata_i[7:0];
            end
            `SSA_STAT_OFS: begin
               n.done = s.done & ~reg_wdata_i[3:0];
            end
            default: begin
               if (reg_addr_i[7:6] == `SSA_CH_SEL) begin
                  case (reg_addr_i[3:2])
                     `SSA_CH_SRC: n.src[wc] = reg_wdata_i;
                     `SSA_CH_DST: n.dst[wc] = reg_wdata_i;
                     `SSA_CH_CNT: n.cnt[wc] = reg_wdata_i[15:0];
                     default: begin
                        n.en[wc] = reg_wdata_i[`SSA_CTL_EN];
                        n.blk[wc] = reg_wdata_i[`SSA_CTL_BLK];
                        n.size[wc] = reg_wdata_i[`SSA_CTL_SIZE +: 2];
                        n.sfwd[wc] = reg_wdata_i[`SSA_CTL_SFWD];
                        n.dfwd[wc] = reg_wdata_i[`SSA_CTL_DFWD];
                        n.rsel[wc] = reg_wdata_i[`SSA_CTL_RSEL +: 2];
                        if (reg_wdata_i[`SSA_CTL_TRIG]) begin
                           n.pend[wc] = 1'b1;
                        end
                     end
                  endcase
               end
            end
         endcase
      end
      if (reg_rd_i) begin
         case (reg_addr_i)
            `SSA_CTRL_OFS: begin
               n.rdata[`SSA_CTRL_CLKSEL] = s.clk_sel;
               n.rdata[`SSA_CTRL_CONTRX] = s.cont_rx;
               n.rdata[`SSA_CTRL_TXREQ] = s.txq_en;
            end
            `SSA_BAUD_OFS: begin
               n.rdata[7:0] = s.baud;
            end
            `SSA_RHB_OFS: begin
               n.rdata[7:0] = rhb;
               n.rhb_rd = 1'b1;
            end
            `SSA_STAT_OFS: begin
               n.rdata[3:0] = s.done;
               n.rdata[`SSA_ST_THBF] = thb_full;
               n.rdata[`SSA_ST_ARMED] = rx_armed;
               n.rdata[`SSA_ST_OVR] = overrun;
               n.rdata[`SSA_ST_BUSY] = (s.st != SSA_IDLE);
            end
            default: begin
               if (reg_addr_i[7:6] == `SSA_CH_SEL) begin
                  case (reg_addr_i[3:2])
                     `SSA_CH_SRC: n.rdata = s.src[wc];
                     `SSA_CH_DST: n.rdata = s.dst[wc];
                     `SSA_CH_CNT: n.rdata[15:0] = s.cnt[wc];
                     default: begin
                        n.rdata[`SSA_CTL_EN] = s.en[wc];
                        n.rdata[`SSA_CTL_BLK] = s.blk[wc];
                        n.rdata[`SSA_CTL_SIZE +: 2] = s.size[wc];
                        n.rdata[`SSA_CTL_SFWD] = s.sfwd[wc];
                        n.rdata[`SSA_CTL_DFWD] = s.dfwd[wc];
                        n.rdata[`SSA_CTL_RSEL +: 2] = s.rsel[wc];
                        n.rdata[`SSA_CTL_TRIG] = s.pend[wc];
                     end
                  endcase
               end
            end
         endcase
      end
      // engine: read one unit, write one unit, then step addresses and count
      case (s.st)
         SSA_IDLE: begin
            if (hit) begin
               n.ch = pk;
               if (!s.blk[pk]) begin
                  n.pend[pk] = 1'b0;
               end
               if (s.src[pk] == `SSA_RHB_ADDR) begin
                  n.data = {24'h00_0000, rhb};
                  n.rhb_rd = 1'b1;
                  go_wr = 1'b1;
               end else begin
                  n.maddr = s.src[pk];
                  n.msize = s.size[pk];
                  n.mrd = 1'b1;
                  n.st = SSA_RD;
               end
            end
         end
         SSA_RD: begin
            if (mem_ack_i) begin
               n.data = mem_rdata_i;
               go_wr = 1'b1;
            end
         end
         SSA_WR: begin
            if (mem_ack_i) begin
               fin = 1'b1;
            end
         end
         default: begin
            n.st = SSA_IDLE;
         end
      endcase
      // trigger set wins over the engine's pick-time clear
      if (reg_wr_i && reg_addr_i[7:6] == `SSA_CH_SEL && reg_addr_i[3:2] == `SSA_CH_CTL &&
            reg_wdata_i[`SSA_CTL_TRIG]) begin
         n.pend[wc] = 1'b1;
      end
      if (go_wr) begin
         if (s.dst[c] == `SSA_THB_ADDR) begin
            n.thb_wr = 1'b1;
            n.thb_d = n.data[7:0];
            fin = 1'b1;
         end else begin
            n.maddr = s.dst[c];
            n.msize = s.size[c];
            n.mwdata = n.data;
            n.mwr = 1'b1;
            n.st = SSA_WR;
         end
      end
      if (fin) begin
         n.st = SSA_IDLE;
         if (s.sfwd[c]) begin
            n.src[c] = s.src[c] + ssa_unit(s.size[c]);
         end
         if (s.dfwd[c]) begin
            n.dst[c] = s.dst[c] + ssa_unit(s.size[c]);
         end
         if (s.cnt[c] <= 16'h0001) begin
            n.cnt[c] = 16'h0000;
            n.en[c] = 1'b0;
            n.pend[c] = 1'b0;
            n.done[c] = 1'b1;
            n.dpulse[c] = 1'b1;
         end else begin
            n.cnt[c] = s.cnt[c] - 16'h0001;
         end
      end
      // requests last, so a request in a clearing cycle survives
      for (int i = 0; i < 4; i++) begin
         if (s.en[i] && ((s.rsel[i] == SSA_REQ_RX && rx_req) || (s.rsel[i] == SSA_REQ_TX && tx_req))) begin
            n.pend[i] = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         s <= '0;
         s.baud <= `SSA_BAUD_RST;
      end else begin
         s <= n;
      end
   end

   assign reg_rdata_o = s.rdata;
   assign mem_addr_o = s.maddr;
   assign mem_size_o = s.msize;
   assign mem_wdata_o = s.mwdata;
   assign mem_rd_o = s.mrd;
   assign mem_wr_o = s.mwr;
   assign xfer_done_o = s.dpulse;

   // ***********************************
   // checks
   // ***********************************
   sequence wr_ack_s;
      s.st == SSA_WR && mem_ack_i;
   endsequence
   sequence rx_pick_s;
      rx_req && s.en[0] && s.rsel[0] == SSA_REQ_RX;
   endsequence

   a_done_at_zero: assert property ((wr_ack_s and s.cnt[s.ch] == 16'h0001) |=>
      (s.dpulse[$past(s.ch)] && !s.en[$past(s.ch)] && s.st == SSA_IDLE))
      else $error("completion not raised at zero count");
   a_dst_forward: assert property ((wr_ack_s and s.dfwd[s.ch] && s.size[s.ch] == SSA_BYTE && !reg_wr_i)
      |=> (s.dst[$past(s.ch)] == $past(s.dst[s.ch]) + 32'h0000_0001))
      else $error("forward destination did not step one byte");
   a_dst_fixed: assert property ((wr_ack_s and !s.dfwd[s.ch] && !reg_wr_i) |=> $stable(s.dst))
      else $error("fixed destination moved");
   a_rx_trigger: assert property (rx_pick_s |=> s.pend[0])
      else $error("receive request not latched");
   a_read_issue: assert property ((s.st == SSA_IDLE && hit && s.src[pk] != `SSA_RHB_ADDR) |=>
      (s.mrd && s.st == SSA_RD && s.maddr == $past(s.src[pk])))
      else $error("memory read not issued for channel");

   sequence thb_fill_s;
      s.st == SSA_RD && mem_ack_i && s.dst[s.ch] == `SSA_THB_ADDR;
   endsequence
   sequence tx_pick_s;
      tx_req && s.en[1] && s.rsel[1] == SSA_REQ_TX;
   endsequence

   a_play_fixed: assert property ((thb_fill_s and !s.dfwd[s.ch] && !reg_wr_i) |=>
      (s.thb_wr && s.thb_d == $past(mem_rdata_i[7:0]) && $stable(s.dst)))
      else $error("playback byte not moved to transmit buffer");
   a_rx_to_mem: assert property ((s.st == SSA_IDLE && hit && s.src[pk] == `SSA_RHB_ADDR &&
      s.dst[pk] != `SSA_THB_ADDR) |=> (s.rhb_rd && s.mwr && s.mwdata[7:0] == $past(rhb)))
      else $error("received byte not moved to memory");
   a_tx_trigger: assert property (tx_pick_s |=> s.pend[1])
      else $error("transmit request not latched");
   a_thb_full: assert property (s.thb_wr |=> thb_full)
      else $error("transmit buffer write not held");
   a_count_step: assert property ((wr_ack_s and s.cnt[s.ch] > 16'h0001 && !reg_wr_i) |=>
      (s.cnt[$past(s.ch)] == $past(s.cnt[s.ch]) - 16'h0001))
      else $error("count did not step by one");
   a_done_sticky: assert property ((s.done != 4'h0 && !(reg_wr_i && reg_addr_i == `SSA_STAT_OFS)) |=>
      ((s.done & $past(s.done)) == $past(s.done)))
      else $error("completion flag lost without a clear");
endmodule

/* bench/ssa_codec_model.sv */
`timescale 1ns/1ps
// ****
// far-side codec, left justified, drives the bit clock
// ****
module ssa_codec_model (
   output logic bclk_o,
   output logic sd_o,
   input logic sd_i
);
   logic ws;
   // clock stands low between frames
   initial begin
      bclk_o = 1'b0;
      sd_o = 1'b0;
      ws = 1'b0;
   end
   // half period chosen unrelated to the system clock
   task automatic word(input logic [15:0] w, output logic [15:0] heard);
      begin
         ws = ~ws;
         for (int i = 15; i >= 0; i--) begin
            sd_o = w[i];
            #730;
            bclk_o = 1'b1;
            heard[i] = sd_i;
            #730;
            bclk_o = 1'b0;
         end
         // released line must not show a stale bit
         sd_o = ~w[0];
      end
   endtask
endmodule

/* bench/test_ssa_top.sv */
`timescale 1ns/1ps
`include "ssa_map.svh"
module test_ssa_top;
   logic sys_clk_i, reset_i, reg_wr_i, reg_rd_i, ext_clk, rx, serial_tx_o, serial_clk_o;
   logic [7:0] reg_addr_i;
   logic [31:0] reg_wdata_i, reg_rdata_o, mem_addr_o, mem_wdata_o, mem_rdata_i, rd;
   logic [1:0] mem_size_o, ack_wait;
   logic mem_rd_o, mem_wr_o, mem_ack_i, wr_pend;
   logic [3:0] xfer_done_o, done_seen, nw;
   logic [31:0] wa [0:7];
   logic [7:0] wd [0:7];
   logic [15:0] heard;
   int n_fail, samples_checked;
   ssa_top dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .external_serial_clock_pin_i(ext_clk), .serial_rx_i(rx), .serial_tx_o(serial_tx_o),
      .serial_clk_o(serial_clk_o), .mem_addr_o(mem_addr_o), .mem_size_o(mem_size_o),
      .mem_wdata_o(mem_wdata_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_rdata_i(mem_rdata_i),
      .mem_ack_i(mem_ack_i), .xfer_done_o(xfer_done_o));
   ssa_codec_model codec (.bclk_o(ext_clk), .sd_o(rx), .sd_i(serial_tx_o));
   // ****
   // clock and memory model, acks two cycles late
   // ****
   initial begin
      sys_clk_i = 1'b0;
      forever #50 sys_clk_i = ~sys_clk_i;
   end
   always @(posedge sys_clk_i) begin
      if (reset_i) begin
         mem_ack_i <= 1'b0;
         mem_rdata_i <= 32'h0;
         ack_wait <= 2'h0;
         wr_pend <= 1'b0;
         done_seen <= 4'h0;
         nw <= 4'h0;
      end else begin
         done_seen <= done_seen | xfer_done_o;
         if (mem_rd_o || mem_wr_o) begin
            ack_wait <= 2'h2;
            wr_pend <= mem_wr_o;
         end else if (ack_wait != 2'h0) begin
            ack_wait <= ack_wait - 2'h1;
         end
         // read data only means something in the ack cycle
         if (ack_wait == 2'h1 && !(mem_rd_o || mem_wr_o)) begin
            mem_ack_i <= 1'b1;
            mem_rdata_i <= {24'h0, mem_addr_o[7:0] ^ 8'h3c};
            if (wr_pend) begin
               wa[nw[2:0]] <= mem_addr_o;
               wd[nw[2:0]] <= mem_wdata_o[7:0];
               nw <= nw + 4'h1;
            end
         end else begin
            mem_ack_i <= 1'b0;
            mem_rdata_i <= ~mem_rdata_i;
         end
      end
   end
   // ****
   // bus and compare tasks
   // ****
   task reg_write(input logic [7:0] a, input logic [31:0] d);
      begin
         @(posedge sys_clk_i);
         reg_addr_i <= a;
         reg_wdata_i <= d;
         reg_wr_i <= 1'b1;
         @(posedge sys_clk_i);
         reg_wr_i <= 1'b0;
      end
   endtask
   task reg_read(input logic [7:0] a, output logic [31:0] d);
      begin
         @(posedge sys_clk_i);
         reg_addr_i <= a;
         reg_rd_i <= 1'b1;
         @(posedge sys_clk_i);
         reg_rd_i <= 1'b0;
         @(negedge sys_clk_i);
         d = reg_rdata_o;
      end
   endtask
   task check(input string what, input logic [31:0] exp, input logic [31:0] got);
      begin
         samples_checked++;
         if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
         end
      end
   endtask
   task chan(input logic [7:0] b, input logic [31:0] s, input logic [31:0] d, input logic [31:0] c,
         input logic [31:0] ctl);
      begin
         reg_write(b, s);
         reg_write(b + 8'h04, d);
         reg_write(b + 8'h08, c);
         reg_write(b + 8'h0c, ctl);
      end
   endtask
   task complete_run;
      begin
         $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
         if (n_fail == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask
   // ****
   // scenarios
   // ****
   task test_reset;
      begin
         reg_read(`SSA_CTRL_OFS, rd);
         check("ctrl reset", 32'h0, rd);
         // pin source before the divider's first rise, so the bit counter starts on a byte edge
         reg_write(`SSA_CTRL_OFS, 32'h1);
         reg_read(`SSA_CTRL_OFS, rd);
         check("clock select", 32'h1, rd);
         reg_read(`SSA_BAUD_OFS, rd);
         check("baud reset", {24'h0, `SSA_BAUD_RST}, rd);
         reg_read(`SSA_STAT_OFS, rd);
         check("status reset", 32'h0, rd);
         reg_write(8'h40, 32'hffff_ffff);
         reg_read(8'h40, rd);
         check("unmapped", 32'h0, rd);
         $display("test reset done");
      end
   endtask
   task test_clock;
      int n;
      logic v;
      begin
         reg_write(`SSA_BAUD_OFS, 32'h7);
         reg_read(`SSA_BAUD_OFS, rd);
         check("baud", 32'h7, rd);
         v = serial_clk_o;
         n = 0;
         while (serial_clk_o === v && n < 100) begin
            @(negedge sys_clk_i);
            n++;
         end
         v = serial_clk_o;
         n = 0;
         while (serial_clk_o === v && n < 100) begin
            @(negedge sys_clk_i);
            n++;
         end
         check("half period", 32'h8, n);
         $display("test clock done");
      end
   endtask
   // record on channel 0 and play on channel 1 at once
   task test_duplex;
      begin
         reg_write(`SSA_CTRL_OFS, 32'h7);
         reg_read(`SSA_RHB_OFS, rd);
         chan(8'h80, `SSA_RHB_ADDR, 32'h100, 32'h2, 32'h61);
         chan(8'h90, 32'h200, `SSA_THB_ADDR, 32'h2, 32'h191);
         repeat (60) @(posedge sys_clk_i);
         codec.word(16'ha55a, heard);
         repeat (40) @(posedge sys_clk_i);
         check("tx bits", 32'h3c3d, {16'h0, heard});
         check("writes", 32'h2, {28'h0, nw});
         check("addr0", 32'h100, wa[0]);
         check("data0", 32'ha5, {24'h0, wd[0]});
         check("addr1", 32'h101, wa[1]);
         check("data1", 32'h5a, {24'h0, wd[1]});
         check("done pulses", 32'h3, {28'h0, done_seen});
         check("mem size", 32'h0, {30'h0, mem_size_o});
         reg_read(`SSA_STAT_OFS, rd);
         check("done sticky", 32'h3, rd & 32'hf);
         reg_write(`SSA_STAT_OFS, 32'hf);
         reg_read(`SSA_STAT_OFS, rd);
         check("done clear", 32'h0, rd & 32'hf);
         $display("test duplex done");
      end
   endtask
   // no consumer: second byte finds the buffer unread
   task test_overrun;
      begin
         codec.word(16'h00ff, heard);
         repeat (20) @(posedge sys_clk_i);
         reg_read(`SSA_STAT_OFS, rd);
         check("overrun set", 32'h40, rd & 32'h60);
         reg_read(`SSA_RHB_OFS, rd);
         check("kept byte", 32'h0, rd & 32'hff);
         reg_read(`SSA_STAT_OFS, rd);
         check("rearmed", 32'h20, rd & 32'h60);
         $display("test overrun done");
      end
   endtask
   initial begin
      repeat (20000) @(posedge sys_clk_i);
      n_fail++;
      complete_run();
   end
   initial begin
      reset_i = 1'b1;
      reg_addr_i = 8'h0;
      reg_wdata_i = 32'h0;
      reg_wr_i = 1'b0;
      reg_rd_i = 1'b0;
      n_fail = 0;
      samples_checked = 0;
      repeat (16) @(posedge sys_clk_i);
      reset_i <= 1'b0;
      test_reset();
      test_clock();
      test_duplex();
      test_overrun();
      complete_run();
   end
endmodule
